// >>> verif/isa_bus_control_glue_test.sv
// Purpose: Self-checking bench for the expansion bus glue block.
// Assumes: Slave model decodes its size from sa[11:10].
// Notes:   Short reset-drive count keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module isa_bus_control_glue_test;
  import isg_pkg::*;
  logic        clk, reset, req_ready, iochrdy, iocs16_n, mem16_n, irq1;
  logic        irq14, pa, pb, pll, rdo, t2, spk, dact, dzero, tpe, tcin;
  logic        tco, tcoe_n, tms, kbd_n, a20, crq_n, ccr;
  logic        str, str_q, dlo, dhi, bhe, kbd;
  logic [7:0]  p61, waits;
  logic [15:0] d_in, irq, rd;
  logic [23:0] ca_in, ca_out;
  logic [11:0] sa_q[$];
  isg_req_s    req;
  isg_rsp_s    rsp;
  isg_isa_s    isa;
  isg_route_s  ra, rb;
  int          err_count, checks_done, slen;

  isg_glue #(.RESET_DRIVE_OUT_CYCLES(16'h0004)) isg_glue_inst (
    .clk(clk), .reset(reset), .req(req), .req_ready(req_ready), .rsp(rsp),
    .isa(isa), .d_in(d_in), .iochrdy(iochrdy), .iocs16_n(iocs16_n),
    .memory_size16_in_n(mem16_n), .irq1_in(irq1), .irq14_in(irq14),
    .routable_irq_a(pa), .routable_irq_b(pb), .route_a(ra), .route_b(rb),
    .irq_req(irq), .pll_locked(pll), .reset_drive_out(rdo),
    .timer2_out(t2), .port61(p61), .speaker_out(spk), .dma_active(dact),
    .dma_count_zero(dzero), .test_port_enable(tpe), .tc_in(tcin),
    .tc_out(tco), .tc_oe_n(tcoe_n), .test_mode_select(tms),
    .keyboard_ctrl_select_n(kbd_n), .addr20_gate_in(a20),
    .cpu_addr_in(ca_in), .cpu_addr_out(ca_out),
    .cpu_reset_request_n(crq_n), .cpu_core_reset(ccr));
  isg_slave_model isg_slave_model_inst (.clk(clk), .isa(isa),
    .waits(waits), .d_in(d_in), .iochrdy(iochrdy), .iocs16_n(iocs16_n),
    .memory_size16_in_n(mem16_n));

  assign str = ~(isa.ior_n & isa.iow_n & isa.memr_n & isa.memw_n);
  always @(posedge clk) begin
    if (str && !str_q)
      sa_q.push_back(isa.sa);
    slen += str;
    dlo |= isa.dir_lo;
    dhi |= isa.dir_hi;
    bhe |= ~isa.sbhe_n;
    kbd |= str & ~kbd_n;
    str_q = str;
  end

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Waits are bounded; a hang ends the run as a mismatch
  task automatic xfer(input logic w, m, input logic [23:0] a,
                      input logic [1:0] be, input logic [15:0] wd);
    int n;
    n = 0;
    sa_q.delete();
    slen = 0;
    {dlo, dhi, bhe, kbd} = 4'h0;
    req = '{1'b1, w, m, a, be, wd};
    step();
    req.valid = 1'b0;
    chk(req_ready, 1'b0);
    while (rsp.valid !== 1'b1) begin
      n++;
      if (n > 300) begin
        err_count++;
        print_verdict();
      end
      step();
    end
    chk(req_ready, 1'b1);
    rd = rsp.rdata;
  endtask : xfer

  task automatic t_reset_drive_out();
    int n;
    n = 0;
    chk(rdo, 1'b1);
    pll = 1'b1;
    while (rdo !== 1'b0 && n < 20) begin
      step();
      n++;
    end
    chk(n, 4);
  endtask : t_reset_drive_out

  task automatic t_io16();
    xfer(1'b1, 1'b0, 24'h000802, 2'h3, 16'ha55a);
    chk(sa_q.size(), 1);
    chk(sa_q[0], 12'h802);
    chk({dlo, dhi, bhe}, 3'h7);
    chk(slen, CMD_CYC);
    xfer(1'b0, 1'b0, 24'h000802, 2'h3, 16'h0);
    chk(rd, 16'ha55a);
    chk({dlo, dhi}, 2'h0);
  endtask : t_io16

  task automatic t_mem8();
    xfer(1'b1, 1'b1, 24'h010100, 2'h3, 16'h1234);
    chk({sa_q[0], sa_q[1]}, {12'h100, 12'h101});
    chk(dhi, 1'b0);
    xfer(1'b0, 1'b1, 24'h010100, 2'h3, 16'h0);
    chk(rd, 16'h1234);
    xfer(1'b1, 1'b1, 24'h010103, 2'h2, 16'hab00);
    chk({dhi, bhe}, 2'h1);
    xfer(1'b0, 1'b1, 24'h010103, 2'h2, 16'h0);
    chk(rd[15:8], 8'hab);
  endtask : t_mem8

  task automatic t_mem16();
    xfer(1'b1, 1'b1, 24'h000c04, 2'h3, 16'hbeef);
    chk(sa_q.size(), 1);
    xfer(1'b0, 1'b1, 24'h000c04, 2'h3, 16'h0);
    chk(rd, 16'hbeef);
  endtask : t_mem16

  task automatic t_wait();
    waits = 8'd40;
    xfer(1'b0, 1'b0, 24'h000802, 2'h3, 16'h0);
    waits = 8'd0;
    chk(slen > 40 && slen <= 40 + CMD_CYC, 1'b1);
    chk(rd, 16'ha55a);
  endtask : t_wait

  // A10 set still decodes; odd and out-of-range do not
  task automatic t_kbd();
    logic [23:0] ad [7] = '{24'h60, 24'h64, 24'h6e, 24'h460, 24'h65,
                            24'h70, 24'h5e};
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 1'b0, ad[i], ad[i][0] ? 2'h2 : 2'h1, 16'h0);
      chk(kbd, i < 4);
    end
  endtask : t_kbd

  task automatic t_glue();
    for (int i = 0; i < 4; i++) begin
      t2 = i[0];
      p61 = i[1] ? 8'h02 : 8'hfd;
      step(2);
      chk(spk, i == 3);
    end
    ca_in = 24'hffffff;
    step(4);
    chk(ca_out, 24'hefffff);
    a20 = 1'b1;
    step(4);
    chk(ca_out, 24'hffffff);
    crq_n = 1'b0;
    step(4);
    chk(ccr, 1'b1);
    crq_n = 1'b1;
    step(5);
    chk(ccr, 1'b0);
  endtask : t_glue

  task automatic t_tc();
    {dact, dzero} = 2'h3;
    step(2);
    chk({tco, tcoe_n}, 2'h2);
    dzero = 1'b0;
    step(2);
    chk(tco, 1'b0);
    {tpe, tcin} = 2'h3;
    step(4);
    chk({tcoe_n, tms}, 2'h3);
    tcin = 1'b0;
    step(4);
    chk({tcoe_n, tms}, 2'h2);
    {tpe, tcin} = 2'h1;
    step(4);
    chk({tcoe_n, tms}, 2'h0);
  endtask : t_tc

  task automatic t_irq();
    {irq1, pa} = 2'h3;
    ra = '{1'b1, 4'h6};
    step(4);
    chk(irq, 16'h0042);
    {irq1, irq14, pa, pb} = 4'h5;
    rb = '{1'b1, 4'h3};
    step(4);
    chk(irq, 16'h4008);
    rb.en = 1'b0;
    step(1);
    chk(irq, 16'h4000);
  endtask : t_irq

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    {req, ra, rb, waits, p61, ca_in} = '0;
    {irq1, irq14, pa, pb, pll, t2, dact, dzero, tpe, tcin, a20} = '0;
    crq_n = 1'b1;
    str_q = 1'b0;
    err_count = 0;
    checks_done = 0;
    step(6);
    chk({rdo, ccr, isa.ior_n}, 3'h7);
    reset = 1'b0;
    step(6);
    chk(ccr, 1'b0);
    t_reset_drive_out();
    t_io16();
    t_mem8();
    t_mem16();
    t_wait();
    t_kbd();
    t_glue();
    t_tc();
    t_irq();
    print_verdict();
  end
endmodule : isa_bus_control_glue_test
`default_nettype wire

// >>> verif/isg_slave_model.sv
// Purpose: Behavioural expansion slave, byte memory with size decode.
// Assumes: sa[11:10] of 10 is an I/O-16 board, 11 a memory-16 board.
// Notes:   Released data bus shows the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module isg_slave_model (
  input  wire logic              clk,
  input  wire isg_pkg::isg_isa_s isa,
  input  wire logic [7:0]        waits,
  output logic [15:0]            d_in,
  output logic                   iochrdy,
  output logic                   iocs16_n,
  output logic                   memory_size16_in_n
);
  import isg_pkg::*;
  logic [7:0]  mem [4096];
  logic [15:0] last_q;
  logic [7:0]  wcnt_q;
  logic        rd, wr, str_q, wide;
  logic [11:0] ev;
  assign rd = ~(isa.ior_n & isa.memr_n);
  assign wr = ~(isa.iow_n & isa.memw_n);
  assign ev = {isa.sa[11:1], 1'b0};
  // Size low only while own range is addressed
  assign iocs16_n           = isa.sa[11:10] != 2'h2;
  assign memory_size16_in_n = isa.sa[11:10] != 2'h3;
  assign wide               = isa.sa[11];
  // Slow slave holds ready low from strobe start
  assign iochrdy = wcnt_q == 8'h0;
  // Drive only under a read strobe; 8-bit board on low lane
  assign d_in = !rd ? ~last_q : wide ? {mem[ev + 12'h1], mem[ev]}
              : {~last_q[15:8], mem[isa.sa]};
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_q = 16'h0;
    wcnt_q = 8'h0;
    str_q = 1'b0;
  end
  always @(posedge clk) begin
    if (rd)
      last_q <= d_in;
    if ((rd | wr) && !str_q)
      wcnt_q <= waits;
    else if (wcnt_q != 8'h0)
      wcnt_q <= wcnt_q - 8'h1;
    str_q <= rd | wr;
    // Latch while the write strobe is low
    if (wr && wide && !isa.sa[0])
      mem[ev] <= isa.dout[7:0];
    if (wr && wide && !isa.sbhe_n)
      mem[ev + 12'h1] <= isa.dout[15:8];
    if (wr && !wide)
      mem[isa.sa] <= isa.dout[7:0];
  end
endmodule : isg_slave_model
`default_nettype wire

// >>> verilog/isg_glue.sv
// Purpose: Expansion bus command sequencer plus system glue signals.
// Assumes: Core requests come from logic on clk; bus pins are async.
// Notes:   Pin inputs are synchronised, so waits lag by two cycles.
`timescale 1ns/1ps
`default_nettype none
module isg_glue #(
  parameter logic [15:0] RESET_DRIVE_OUT_CYCLES = 16'h1000
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire isg_pkg::isg_req_s  req,
  output logic                    req_ready,
  output isg_pkg::isg_rsp_s       rsp,
  output isg_pkg::isg_isa_s       isa,
  input  wire logic [15:0]        d_in,
  input  wire logic               iochrdy,
  input  wire logic               iocs16_n,
  input  wire logic               memory_size16_in_n,
  input  wire logic               irq1_in,
  input  wire logic               irq14_in,
  input  wire logic               routable_irq_a,
  input  wire logic               routable_irq_b,
  input  wire isg_pkg::isg_route_s route_a,
  input  wire isg_pkg::isg_route_s route_b,
  output logic [15:0]             irq_req,
  input  wire logic               pll_locked,
  output logic                    reset_drive_out,
  input  wire logic               timer2_out,
  input  wire logic [7:0]         port61,
  output logic                    speaker_out,
  input  wire logic               dma_active,
  input  wire logic               dma_count_zero,
  input  wire logic               test_port_enable,
  input  wire logic               tc_in,
  output logic                    tc_out,
  output logic                    tc_oe_n,
  output logic                    test_mode_select,
  output logic                    keyboard_ctrl_select_n,
  input  wire logic               addr20_gate_in,
  input  wire logic [23:0]        cpu_addr_in,
  output logic [23:0]             cpu_addr_out,
  input  wire logic               cpu_reset_request_n,
  output logic                    cpu_core_reset
);
  import isg_pkg::*;

  localparam int SW = 11;
  localparam logic [SW-1:0] SYNC_RST = 11'h1c7;

  isg_state_s s_q;
  isg_state_s s_d;
  logic [SW-1:0] pin_s;
  logic [15:0]   din_s;
  logic          rdy_s;
  logic          size16_s;
  logic          a20_s;
  logic          rc_n_s;
  logic          tms_s;
  logic [3:0]    irq_s;
  logic          test_s;

  // Ready, both sizing pins, test enable and the two fixed IRQ pins reset to one; reset request resets to zero
  isg_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({routable_irq_b, routable_irq_a, irq14_in, irq1_in,
             test_port_enable, tc_in, cpu_reset_request_n,
             addr20_gate_in, memory_size16_in_n, iocs16_n, iochrdy}),
    .q     (pin_s)
  );

  isg_sync #(.W(16), .RST_VAL(16'h0000)) u_data_sync (
    .clk   (clk),
    .reset (reset),
    .d     (d_in),
    .q     (din_s)
  );

  assign rdy_s    = pin_s[0];
  // Sizing pins cross apart; the OR only sees settled flops
  assign size16_s = !(pin_s[1] & pin_s[2]);
  assign a20_s    = pin_s[3];
  assign rc_n_s   = pin_s[4];
  assign tms_s    = pin_s[5];
  assign test_s   = pin_s[6];
  assign irq_s    = pin_s[10:7];

  // Interrupt request fabric
  for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
    always_comb begin
      irq_req[i] = (route_a.en && route_a.chan == 4'(i) && irq_s[2]) ||
                   (route_b.en && route_b.chan == 4'(i) && irq_s[3]);
      if (i == IRQ_KBD) irq_req[i] = irq_req[i] | irq_s[0];
      if (i == IRQ_DISK) irq_req[i] = irq_req[i] | irq_s[1];
    end
  end

  always_comb begin
    logic hi_byte;
    logic kbd_hit;
    hi_byte = 1'b0;
    kbd_hit = 1'b0;
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (req.valid) begin
          hi_byte       = (req.be == BE_HIGH);
          s_d.st        = ST_ADDR;
          s_d.cnt       = ADDR_CNT;
          s_d.write     = req.write;
          s_d.mem       = req.mem;
          s_d.wdata     = req.wdata;
          s_d.rdata     = 16'h0000;
          s_d.split     = (req.be == BE_WORD);
          s_d.phase     = 1'b0;
          s_d.addr      = {req.addr[23:1], hi_byte};
          s_d.isa.sa    = {req.addr[11:1], hi_byte};
          s_d.isa.sbhe_n = !req.be[1];
        end
      end
      ST_ADDR: begin
        if (s_q.cnt != CNT_ZERO) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          // Sizing sampled after the target had time to decode
          s_d.wide = size16_s;
          s_d.st   = ST_CMD;
          s_d.cnt  = CMD_CNT;
          s_d.isa.ior_n  = !(!s_q.mem && !s_q.write);
          s_d.isa.iow_n  = !(!s_q.mem && s_q.write);
          s_d.isa.memr_n = !(s_q.mem && !s_q.write);
          s_d.isa.memw_n = !(s_q.mem && s_q.write);
          s_d.isa.doe_n  = !s_q.write;
          s_d.isa.dir_lo = s_q.write;
          s_d.isa.dir_hi = s_q.write && size16_s &&
                           !s_q.isa.sbhe_n;
          if (size16_s) begin
            s_d.isa.dout = s_q.wdata;
          end else if (s_q.addr[0]) begin
            s_d.isa.dout = {s_q.wdata[15:8], s_q.wdata[15:8]};
          end else begin
            s_d.isa.dout = s_q.wdata;
          end
        end
      end
      ST_CMD: begin
        if (s_q.cnt != CNT_ZERO) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (rdy_s) begin
          if (s_q.wide) begin
            s_d.rdata = din_s;
          end else if (s_q.addr[0]) begin
            s_d.rdata[15:8] = din_s[7:0];
          end else begin
            s_d.rdata[7:0] = din_s[7:0];
          end
          s_d.st  = ST_REC;
          s_d.cnt = REC_CNT;
          s_d.isa.ior_n  = 1'b1;
          s_d.isa.iow_n  = 1'b1;
          s_d.isa.memr_n = 1'b1;
          s_d.isa.memw_n = 1'b1;
        end
      end
      ST_REC: begin
        // Data held one cycle past the strobe for hold time
        s_d.isa.doe_n  = 1'b1;
        s_d.isa.dir_lo = 1'b0;
        s_d.isa.dir_hi = 1'b0;
        if (s_q.cnt != CNT_ZERO) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.split && !s_q.wide && !s_q.phase) begin
          s_d.phase     = 1'b1;
          s_d.addr[0]   = 1'b1;
          s_d.isa.sa[0] = 1'b1;
          s_d.st        = ST_ADDR;
          s_d.cnt       = ADDR_CNT;
        end else begin
          s_d.st        = ST_IDLE;
          s_d.rsp.valid = 1'b1;
          s_d.rsp.rdata = s_d.rdata;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Reset drive stretched until the PLL settles and the count runs out
    if (!pll_locked) begin
      s_d.rst_cnt = RESET_DRIVE_OUT_CYCLES;
    end else if (s_q.rst_cnt != RST_ZERO) begin
      s_d.rst_cnt = s_q.rst_cnt - RST_ONE;
    end
    s_d.rst_drv = (s_d.rst_cnt != RST_ZERO);

    s_d.spk = timer2_out & port61[SPK_EN_BIT];
    s_d.tc  = dma_active & dma_count_zero & !test_s;
    // Next-state decode keeps the select aligned with each byte cycle
    kbd_hit = !s_d.mem && s_d.st != ST_IDLE &&
              s_d.addr[9:0] >= KBD_LO && s_d.addr[9:0] <= KBD_HI &&
              !s_d.addr[0];
    s_d.kbd_n    = !kbd_hit;
    s_d.cpu_addr = cpu_addr_in;
    s_d.cpu_addr[A20_BIT] = cpu_addr_in[A20_BIT] & a20_s;
    s_d.core_rst = !rc_n_s;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q            <= '0;
      s_q.st         <= ST_IDLE;
      s_q.isa.sbhe_n <= 1'b1;
      s_q.isa.ior_n  <= 1'b1;
      s_q.isa.iow_n  <= 1'b1;
      s_q.isa.memr_n <= 1'b1;
      s_q.isa.memw_n <= 1'b1;
      s_q.isa.doe_n  <= 1'b1;
      s_q.rst_cnt    <= RESET_DRIVE_OUT_CYCLES;
      s_q.rst_drv    <= 1'b1;
      s_q.kbd_n      <= 1'b1;
      s_q.core_rst   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready        = (s_q.st == ST_IDLE);
  assign rsp              = s_q.rsp;
  assign isa              = s_q.isa;
  assign reset_drive_out  = s_q.rst_drv;
  assign speaker_out      = s_q.spk;
  assign tc_out           = s_q.tc;
  assign tc_oe_n          = test_s;
  assign test_mode_select = test_s ? tms_s : 1'b0;
  assign keyboard_ctrl_select_n = s_q.kbd_n;
  assign cpu_addr_out     = s_q.cpu_addr;
  assign cpu_core_reset   = s_q.core_rst | reset;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic any_strb_n;
  assign any_strb_n = isa.ior_n & isa.iow_n & isa.memr_n & isa.memw_n;

  sequence strobe_open;
    $fell(any_strb_n);
  endsequence
  sequence held_min;
    !any_strb_n [*8];
  endsequence
  sequence second_addr;
    s_q.st == ST_ADDR && isa.sa[0];
  endsequence

  // Buffer direction and lane use
  lo_dir_write_a: assert property (
    (!isa.iow_n || !isa.memw_n) |-> isa.dir_lo && !isa.doe_n)
    else $error("low lane direction not outward during write");
  lo_dir_read_a: assert property (isa.dir_lo |-> s_q.write)
    else $error("low lane direction outward outside a write");
  hi_dir_use_a: assert property (
    isa.dir_hi |-> s_q.write && s_q.wide && !isa.sbhe_n)
    else $error("high lane direction without high byte write");
  narrow_lane_a: assert property (
    (!s_q.wide && s_q.st == ST_CMD) |-> !isa.dir_hi)
    else $error("8-bit target uses high lane");
  sbhe_lane_a: assert property (
    s_q.st == ST_CMD |-> isa.sbhe_n == !(s_q.split || s_q.addr[0]))
    else $error("byte high enable does not match the access");
  sa_latch_a: assert property (
    s_q.st != ST_IDLE |-> isa.sa == s_q.addr[11:0])
    else $error("low address lines differ from the cycle address");

  // Command strobe timing and sizing
  wait_hold_a: assert property (
    (s_q.st == ST_CMD && !rdy_s && !any_strb_n) |=> !any_strb_n)
    else $error("strobe ended while ready low");
  ready_end_a: assert property (
    (s_q.st == ST_CMD && s_q.cnt == CNT_ZERO && rdy_s) |=> any_strb_n)
    else $error("strobe kept after ready and full width");
  strobe_width_a: assert property (strobe_open |-> held_min)
    else $error("command strobe shorter than minimum");
  one_strobe_a: assert property (
    $onehot0({!isa.ior_n, !isa.iow_n, !isa.memr_n, !isa.memw_n}))
    else $error("more than one command strobe low");
  size_sample_a: assert property (
    (s_q.st == ST_ADDR && s_q.cnt == CNT_ZERO)
    |=> s_q.wide == !($past(pin_s[1]) && $past(pin_s[2])))
    else $error("sizing inputs not combined by OR");
  split_second_a: assert property (
    (s_q.st == ST_REC && s_q.cnt == CNT_ZERO && s_q.split && !s_q.wide
    && !s_q.phase) |=> second_addr ##[1:12] !any_strb_n)
    else $error("split access missing second byte cycle");

  // Glue outputs, one register stage behind their inputs except the combinational IRQ requests, tc_oe_n and test_mode_select
  spk_gate_a: assert property (!$past(reset) |-> speaker_out
    == ($past(timer2_out) & $past(port61[SPK_EN_BIT])))
    else $error("speaker not timer AND enable");
  tc_gate_a: assert property (
    !$past(test_s)
    |-> tc_out == ($past(dma_active) && $past(dma_count_zero)))
    else $error("terminal count not on last transfer");
  tc_test_a: assert property (
    test_s && $past(test_s) |-> tc_oe_n && !tc_out)
    else $error("terminal count driven in test mode");
  kbd_range_a: assert property (!keyboard_ctrl_select_n
    |-> !s_q.addr[0] && s_q.addr[9:0] >= KBD_LO
    && s_q.addr[9:0] <= KBD_HI)
    else $error("keyboard select outside its range");
  a20_force_a: assert property (!$past(a20_s)
    |-> !cpu_addr_out[A20_BIT])
    else $error("address bit 20 not forced low");
  core_reset_a: assert property (!$past(rc_n_s) |-> cpu_core_reset)
    else $error("core not reset on reset request");
  kbd_irq_a: assert property (irq_s[0] |-> irq_req[IRQ_KBD])
    else $error("fixed request missing on its low channel");
  disk_irq_a: assert property (irq_s[1] |-> irq_req[IRQ_DISK])
    else $error("fixed request missing on its high channel");
  route_irq_a: assert property (
    (route_a.en && irq_s[2]) |-> irq_req[route_a.chan])
    else $error("routable request not on its channel");
  rst_stretch_a: assert property (
    !pll_locked |=> reset_drive_out [*2])
    else $error("reset drive dropped before PLL lock");
endmodule : isg_glue
`default_nettype wire

// >>> verilog/isg_pkg.sv
// Purpose: Shared constants and types for the expansion bus glue block.
// Assumes: 200 MHz core clock, all bus timing counted in that clock.
// Notes:   Bus strobe times are minimums and round up to whole cycles.
`default_nettype none
package isg_pkg;
  localparam int CLK_NS   = 5;
  localparam int ADDR_NS  = 20;
  localparam int CMD_NS   = 125;
  localparam int REC_NS   = 40;
  localparam int ADDR_CYC = (ADDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CMD_CYC  = (CMD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC  = (REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 8;
  localparam logic [CNT_W-1:0] ADDR_CNT = CNT_W'(ADDR_CYC - 1);
  localparam logic [CNT_W-1:0] CMD_CNT  = CNT_W'(CMD_CYC - 1);
  localparam logic [CNT_W-1:0] REC_CNT  = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
  localparam int RST_W    = 16;
  localparam logic [RST_W-1:0] RST_ZERO = RST_W'(0);
  localparam logic [RST_W-1:0] RST_ONE  = RST_W'(1);
  localparam logic [9:0] KBD_LO    = 10'h060;
  localparam logic [9:0] KBD_HI    = 10'h06e;
  localparam int A20_BIT           = 20;
  localparam int SPK_EN_BIT        = 1;
  localparam int IRQ_KBD           = 1;
  localparam int IRQ_DISK          = 14;
  localparam int IRQ_N             = 16;
  localparam logic [7:0] PIRQ_CFG_INDEX = 8'hb2;
  localparam logic [1:0] BE_WORD   = 2'h3;
  localparam logic [1:0] BE_HIGH   = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_REC} isg_st_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        mem;
    logic [23:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } isg_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } isg_rsp_s;

  typedef struct packed {
    logic        en;
    logic [3:0]  chan;
  } isg_route_s;

  typedef struct packed {
    logic [11:0] sa;
    logic        sbhe_n;
    logic        ior_n;
    logic        iow_n;
    logic        memr_n;
    logic        memw_n;
    logic        dir_lo;
    logic        dir_hi;
    logic [15:0] dout;
    logic        doe_n;
  } isg_isa_s;

  typedef struct packed {
    isg_st_e          st;
    logic [CNT_W-1:0] cnt;
    logic             split;
    logic             phase;
    logic             wide;
    logic             write;
    logic             mem;
    logic [23:0]      addr;
    logic [15:0]      wdata;
    logic [15:0]      rdata;
    isg_rsp_s         rsp;
    isg_isa_s         isa;
    logic [RST_W-1:0] rst_cnt;
    logic             rst_drv;
    logic             spk;
    logic             tc;
    logic             kbd_n;
    logic [23:0]      cpu_addr;
    logic             core_rst;
  } isg_state_s;
endpackage : isg_pkg
`default_nettype wire

// >>> verilog/isg_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are levels, each bit crossing on its own.
// Notes:   Reset value per bit lets pulled-up pins idle high.
`timescale 1ns/1ps
`default_nettype none
module isg_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : isg_sync
`default_nettype wire
